//--- rtl/cpuif_cfg.svh
// Purpose: Constants for the processor-interface request signaling block
// Assumes: Included by bare name; definitions only
// Notes:   Field positions index the per-core control word
`ifndef CPUIF_CFG_SVH
`define CPUIF_CFG_SVH

`define CPUIF_NCPU        2
`define CPUIF_SEC_PRESENT 2'h1
`define CPUIF_CTRL_W      7
`define CPUIF_CTRL_RST    7'h00
`define CPUIF_CTRL_COMMON 7'h52
`define CPUIF_BIT_G0EN    0
`define CPUIF_BIT_G1EN    1
`define CPUIF_BIT_FSEL    2
`define CPUIF_BIT_NBD0    3
`define CPUIF_BIT_NBD1    4
`define CPUIF_BIT_FBD0    5
`define CPUIF_BIT_FBD1    6
`define CPUIF_APR_W       32
`define CPUIF_APR_RST     32'h0000_0000
`define CPUIF_NIRQ        32
`define CPUIF_NSGI        16
`define CPUIF_ID_W        5
`define CPUIF_GRP_RST     32'h0000_0000

`endif

//--- rtl/cpuif_pkg.sv
// Purpose: Types for the processor-interface request signaling block
// Assumes: cpuif_cfg.svh supplies the widths
// Notes:   Source codes are one-hot
`include "cpuif_cfg.svh"
package cpuif_pkg;
  typedef enum logic [2:0] {
    CPUIF_SRC_OFF = 3'h1,
    CPUIF_SRC_BYP = 3'h2,
    CPUIF_SRC_DRV = 3'h4
  } cpuif_src_e;

  typedef logic [`CPUIF_CTRL_W-1:0] cpuif_ctrl_t;
  typedef logic [`CPUIF_APR_W-1:0]  cpuif_apr_t;
  typedef logic [`CPUIF_ID_W-1:0]   cpuif_id_t;
endpackage

//--- rtl/cpuif_sig_if.sv
// Purpose: Carrier between the top and one request unit
// Assumes: Legacy inputs already synchronised
// Notes:   ctl is the top side, unit the request side
`timescale 1ns/1ps
interface cpuif_sig_if;
  import cpuif_pkg::*;
  cpuif_ctrl_t ctrl;
  logic        pend;
  logic        grp1;
  logic        leg_irq;
  logic        leg_fiq;
  logic        irq;
  logic        fast_interrupt_request;
  logic        wake;
  modport ctl  (output ctrl, pend, grp1, leg_irq, leg_fiq, input irq, fast_interrupt_request, wake);
  modport unit (input ctrl, pend, grp1, leg_irq, leg_fiq, output irq, fast_interrupt_request, wake);
endinterface

//--- rtl/cpuif_req_unit.sv
// Purpose: Normal, fast and wakeup request outputs of one processor interface
// Assumes: Inputs are on CLK domain
// Notes:   Outputs registered, one cycle after the inputs
`timescale 1ns/1ps
`include "cpuif_cfg.svh"
module cpuif_req_unit
  import cpuif_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  cpuif_sig_if.unit sig
);
  // ****************************************
  // Decision
  // ****************************************
  wire g0   = sig.ctrl[`CPUIF_BIT_G0EN];
  wire g1   = sig.ctrl[`CPUIF_BIT_G1EN];
  wire fs   = sig.ctrl[`CPUIF_BIT_FSEL];
  wire nbd0 = sig.ctrl[`CPUIF_BIT_NBD0];
  wire nbd1 = sig.ctrl[`CPUIF_BIT_NBD1];
  wire fbd0 = sig.ctrl[`CPUIF_BIT_FBD0];
  wire fbd1 = sig.ctrl[`CPUIF_BIT_FBD1];

  wire irq_drv_any = g0 & g1 & ~fs;
  wire irq_drv_g1  = g1 & (~g0 | fs);
  wire irq_drv_g0  = g0 & ~g1 & ~fs;
  wire irq_off_byp = nbd1 & (~fs | nbd0);
  cpuif_src_e irq_src;
  assign irq_src = (irq_drv_any | irq_drv_g1 | irq_drv_g0) ? CPUIF_SRC_DRV :
                   irq_off_byp ? CPUIF_SRC_OFF : CPUIF_SRC_BYP;
  wire irq_drv_val = sig.pend & (irq_drv_any | (irq_drv_g1 & sig.grp1) |
                                 (irq_drv_g0 & ~sig.grp1));

  wire fiq_drv     = g0 & fs;
  wire fiq_off_byp = fbd0 & (fs | fbd1);
  cpuif_src_e fiq_src;
  assign fiq_src = fiq_drv ? CPUIF_SRC_DRV :
                   fiq_off_byp ? CPUIF_SRC_OFF : CPUIF_SRC_BYP;
  wire fiq_drv_val = sig.pend & ~sig.grp1;

  logic irq_d;
  logic fiq_d;
  always_comb begin
    case (irq_src)
      CPUIF_SRC_DRV: irq_d = irq_drv_val;
      CPUIF_SRC_BYP: irq_d = sig.leg_irq;
      CPUIF_SRC_OFF: irq_d = 1'b0;
      default:       irq_d = 1'b0;
    endcase
    case (fiq_src)
      CPUIF_SRC_DRV: fiq_d = fiq_drv_val;
      CPUIF_SRC_BYP: fiq_d = sig.leg_fiq;
      CPUIF_SRC_OFF: fiq_d = 1'b0;
      default:       fiq_d = 1'b0;
    endcase
  end

  // ****************************************
  // Output registers
  // ****************************************
  logic irq_q;
  logic fiq_q;
  logic wake_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q  <= 1'b0;
      fiq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      fiq_q  <= fiq_d;
      wake_q <= sig.leg_irq | sig.leg_fiq | sig.pend;
    end
  end
  assign sig.irq  = irq_q;
  assign sig.fast_interrupt_request  = fiq_q;
  assign sig.wake = wake_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fast_owned;
    g0 && fs;
  endsequence
  sequence s_fast_closed;
    !(g0 && fs) && fbd0 && (fs || fbd1);
  endsequence

  fast_drive_a: assert property (s_fast_owned
                                 |=> sig.fast_interrupt_request == $past(sig.pend && !sig.grp1))
    else $error("fast request not driven by interface");
  fast_off_a: assert property (s_fast_closed |=> !sig.fast_interrupt_request)
    else $error("fast request not deasserted");
  fast_byp_a: assert property (!(g0 && fs) && !(fbd0 && (fs || fbd1))
                               |=> sig.fast_interrupt_request == $past(sig.leg_fiq))
    else $error("fast request not bypassed");
  irq_any_a: assert property (g0 && g1 && !fs |=> sig.irq == $past(sig.pend))
    else $error("normal request not driven for any group");
  irq_g0only_a: assert property (g0 && !g1 && !fs && sig.grp1 |=> !sig.irq)
    else $error("group 1 request leaked on normal output");
  irq_off_a: assert property (!g1 && (!g0 || fs) && nbd1 && (!fs || nbd0) |=> !sig.irq)
    else $error("normal request not deasserted");
  wake_live_a: assert property (sig.leg_fiq && fbd0 && fbd1 && !g0 ##1 1 |-> sig.wake)
    else $error("wakeup lost while bypass disabled");
endmodule

//--- rtl/cpuif_top.sv
// Purpose: Processor-interface request signaling for several cores
// Assumes: Legacy request pins are asynchronous; other inputs on CLK_I
// Notes:   Lowest pending interrupt number is offered to each core
`timescale 1ns/1ps
`include "cpuif_cfg.svh"
module cpuif_top
  import cpuif_pkg::*;
(
  input  wire logic                    CLK_I,
  input  wire logic                    RST_N_I,
  input  wire logic [`CPUIF_NCPU-1:0]  LEG_IRQ_I,
  input  wire logic [`CPUIF_NCPU-1:0]  LEG_FIQ_I,
  input  wire logic                    CTRL_WR_I,
  input  wire logic                    CTRL_CPU_I,
  input  wire logic                    CTRL_SECURE_I,
  input  wire logic [`CPUIF_CTRL_W-1:0] CTRL_WDATA_I,
  input  wire logic                    APR_WR_I,
  input  wire logic                    APR_RD_I,
  input  wire logic                    APR_CPU_I,
  input  wire logic                    APR_SECURE_I,
  input  wire logic [`CPUIF_APR_W-1:0] APR_WDATA_I,
  input  wire logic                    GRP_WR_I,
  input  wire logic                    GRP_SECURE_I,
  input  wire logic [`CPUIF_ID_W-1:0]  GRP_ID_I,
  input  wire logic                    GRP_VAL_I,
  input  wire logic                    SGI_SET_I,
  input  wire logic [3:0]              SGI_ID_I,
  input  wire logic [`CPUIF_NCPU-1:0]  SGI_TGT_I,
  input  wire logic                    SPI_SET_I,
  input  wire logic [3:0]              SPI_ID_I,
  input  wire logic [`CPUIF_NCPU-1:0]  ACK_I,
  output logic      [`CPUIF_NCPU-1:0]  IRQ_O,
  output logic      [`CPUIF_NCPU-1:0]  FIQ_O,
  output logic      [`CPUIF_NCPU-1:0]  WAKE_O,
  output logic      [`CPUIF_NCPU-1:0]  REQ_SECURE_O,
  output logic      [`CPUIF_NCPU-1:0]  ACK_VALID_O,
  output logic      [`CPUIF_ID_W-1:0]  ACK_ID0_O,
  output logic      [`CPUIF_ID_W-1:0]  ACK_ID1_O,
  output logic      [`CPUIF_APR_W-1:0] APR_RDATA_O
);
  localparam int N = `CPUIF_NCPU;
  localparam logic [N-1:0] SEC = `CPUIF_SEC_PRESENT;

  // ****************************************
  // Legacy input synchronisers
  // ****************************************
  logic [N-1:0] leg_irq_m_q;
  logic [N-1:0] leg_irq_s_q;
  logic [N-1:0] leg_fiq_m_q;
  logic [N-1:0] leg_fiq_s_q;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      leg_irq_m_q <= '0;
      leg_irq_s_q <= '0;
      leg_fiq_m_q <= '0;
      leg_fiq_s_q <= '0;
    end else begin
      leg_irq_m_q <= LEG_IRQ_I;
      leg_irq_s_q <= leg_irq_m_q;
      leg_fiq_m_q <= LEG_FIQ_I;
      leg_fiq_s_q <= leg_fiq_m_q;
    end
  end

  // ****************************************
  // Control words, secure and common bits
  // ****************************************
  cpuif_ctrl_t ctrl_q [N];
  cpuif_ctrl_t ctrl_mask [N];
  wire ctrl_sec_acc = CTRL_SECURE_I | ~SEC[CTRL_CPU_I];
  assign ctrl_mask[0] = ctrl_sec_acc ? '1 : cpuif_ctrl_t'(`CPUIF_CTRL_COMMON);
  assign ctrl_mask[1] = ctrl_mask[0];

  // ****************************************
  // Active priority copies
  // ****************************************
  cpuif_apr_t apr_s_q  [N];
  cpuif_apr_t apr_ns_q [N];
  logic       apr_rd_q;
  cpuif_apr_t apr_rdata_q;
  wire apr_to_sec = APR_SECURE_I & SEC[APR_CPU_I];
  wire cpuif_apr_t apr_rsel = apr_to_sec ? apr_s_q[APR_CPU_I] : apr_ns_q[APR_CPU_I];

  // ****************************************
  // Interrupt groups and pending state
  // ****************************************
  logic [`CPUIF_NIRQ-1:0] grp_q;
  logic [`CPUIF_NSGI-1:0] sgi_q [N];
  logic [`CPUIF_NSGI-1:0] spi_q;
  logic [`CPUIF_NSGI-1:0] spi_set_vec;
  logic [`CPUIF_NSGI-1:0] spi_clr_vec;
  logic [`CPUIF_NSGI-1:0] sgi_set_vec [N];
  logic [`CPUIF_NSGI-1:0] sgi_clr_vec [N];
  cpuif_id_t              hp_id   [N];
  logic [N-1:0]           hp_pend;
  logic [N-1:0]           ack_ok;
  cpuif_id_t              ack_id_q [N];
  logic [N-1:0]           ack_valid_q;
  logic [N-1:0]           req_sec_q;

  assign spi_set_vec = SPI_SET_I ? (`CPUIF_NSGI'(1) << SPI_ID_I) : '0;

  function automatic cpuif_id_t lowest(input logic [`CPUIF_NIRQ-1:0] v);
    cpuif_id_t r;
    r = '1;
    for (int i = `CPUIF_NIRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = cpuif_id_t'(i);
      end
    end
    return r;
  endfunction

  // Lower-numbered core wins an interrupt offered to both
  always_comb begin
    spi_clr_vec = '0;
    for (int c = 0; c < N; c++) begin
      hp_pend[c]     = |{spi_q, sgi_q[c]};
      hp_id[c]       = lowest({spi_q, sgi_q[c]});
      ack_ok[c]      = ACK_I[c] & hp_pend[c];
      sgi_set_vec[c] = (SGI_SET_I & SGI_TGT_I[c]) ? (`CPUIF_NSGI'(1) << SGI_ID_I) : '0;
      sgi_clr_vec[c] = '0;
      if (ack_ok[c] & hp_id[c][4]) begin
        if (spi_clr_vec[hp_id[c][3:0]]) begin
          ack_ok[c] = 1'b0;
        end else begin
          spi_clr_vec[hp_id[c][3:0]] = 1'b1;
        end
      end else if (ack_ok[c]) begin
        sgi_clr_vec[c][hp_id[c][3:0]] = 1'b1;
      end
    end
  end

  // ****************************************
  // Per-core request units
  // ****************************************
  cpuif_sig_if sig [N] ();
  for (genvar c = 0; c < N; c++) begin : g_cpu
    assign sig[c].ctrl    = ctrl_q[c];
    assign sig[c].pend    = hp_pend[c];
    assign sig[c].grp1    = grp_q[hp_id[c]];
    assign sig[c].leg_irq = leg_irq_s_q[c];
    assign sig[c].leg_fiq = leg_fiq_s_q[c];
    assign IRQ_O[c]       = sig[c].irq;
    assign FIQ_O[c]       = sig[c].fast_interrupt_request;
    assign WAKE_O[c]      = sig[c].wake;

    cpuif_req_unit u_req (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .sig     (sig[c])
    );

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        ctrl_q[c]      <= `CPUIF_CTRL_RST;
        apr_s_q[c]     <= `CPUIF_APR_RST;
        apr_ns_q[c]    <= `CPUIF_APR_RST;
        sgi_q[c]       <= '0;
        ack_id_q[c]    <= '0;
        ack_valid_q[c] <= 1'b0;
        req_sec_q[c]   <= 1'b0;
      end else begin
        if (CTRL_WR_I && CTRL_CPU_I == c) begin
          ctrl_q[c] <= (ctrl_q[c] & ~ctrl_mask[c]) | (CTRL_WDATA_I & ctrl_mask[c]);
        end
        if (APR_WR_I && APR_CPU_I == c && apr_to_sec) begin
          apr_s_q[c] <= APR_WDATA_I;
        end
        if (APR_WR_I && APR_CPU_I == c && !apr_to_sec) begin
          apr_ns_q[c] <= APR_WDATA_I;
        end
        sgi_q[c]       <= (sgi_q[c] & ~sgi_clr_vec[c]) | sgi_set_vec[c];
        ack_valid_q[c] <= ack_ok[c];
        ack_id_q[c]    <= ack_ok[c] ? hp_id[c] : ack_id_q[c];
        req_sec_q[c]   <= SEC[c] & hp_pend[c] & ~grp_q[hp_id[c]];
      end
    end
  end

  // ****************************************
  // Shared state and read port
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      grp_q       <= `CPUIF_GRP_RST;
      spi_q       <= '0;
      apr_rd_q    <= 1'b0;
      apr_rdata_q <= `CPUIF_APR_RST;
    end else begin
      if (GRP_WR_I && GRP_SECURE_I) begin
        grp_q[GRP_ID_I] <= GRP_VAL_I;
      end
      spi_q       <= (spi_q & ~spi_clr_vec) | spi_set_vec;
      apr_rd_q    <= APR_RD_I;
      apr_rdata_q <= APR_RD_I ? apr_rsel : apr_rdata_q;
    end
  end

  assign ACK_VALID_O  = ack_valid_q;
  assign ACK_ID0_O    = ack_id_q[0];
  assign ACK_ID1_O    = ack_id_q[1];
  assign REQ_SECURE_O = req_sec_q;
  assign APR_RDATA_O  = apr_rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  apr_bank_a: assert property (APR_WR_I && !APR_SECURE_I |=> $stable(apr_s_q[0]))
    else $error("non-secure write disturbed secure copy");
  apr_read_a: assert property (APR_RD_I && APR_CPU_I == 0 && !apr_to_sec && !APR_WR_I
                               |=> APR_RDATA_O == apr_ns_q[0])
    else $error("active priority read wrong");
  ctrl_secure_a: assert property (CTRL_WR_I && !CTRL_SECURE_I && CTRL_CPU_I == 0
                                  |=> ctrl_q[0][`CPUIF_BIT_G0EN]
                                      == $past(ctrl_q[0][`CPUIF_BIT_G0EN]))
    else $error("secure bit changed by non-secure write");
  ctrl_common_a: assert property (CTRL_WR_I && CTRL_CPU_I == 0
                                  |=> ctrl_q[0][`CPUIF_BIT_G1EN]
                                      == $past(CTRL_WDATA_I[`CPUIF_BIT_G1EN]))
    else $error("common bit not written");
  grp_secure_a: assert property (GRP_WR_I && !GRP_SECURE_I |=> $stable(grp_q))
    else $error("group changed by non-secure write");
  sgi_local_a: assert property (ack_ok[0] && !hp_id[0][4] && !SGI_SET_I && !ack_ok[1]
                                |=> $stable(sgi_q[1]))
    else $error("software interrupt ack touched other core");
  spi_single_a: assert property (ACK_VALID_O == 2'h3 |-> ACK_ID0_O != ACK_ID1_O
                                 || !ACK_ID0_O[4])
    else $error("peripheral interrupt acknowledged twice");
  req_sec_a: assert property (hp_pend[1] |=> !REQ_SECURE_O[1])
    else $error("secure request on interface without security");
endmodule

//--- sim/cpuif_core_model.sv
// Purpose: Processor core model that acknowledges raised requests
// Assumes: Requests arrive as registered levels from the interface
// Notes:   DELAY sets how slowly the core answers a request
`timescale 1ns/1ps
module cpuif_core_model #(
  parameter int DELAY = 0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic irq_i,
  input  wire logic fiq_i,
  output logic      ack_o
);
  // ************************************************************
  // Acknowledge timing
  // ************************************************************
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  wire        req = irq_i | fiq_i;

  // Holdoff after each acknowledge lets the request drop first
  assign cnt_d = (cnt_q != 5'h00) ? cnt_q - 5'h01 :
                 (en_i && req)    ? 5'(DELAY + 6)  : 5'h00;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 5'h00;
      ack_o <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      ack_o <= (cnt_q == 5'h06) && req;
    end
  end
endmodule

//--- sim/cpuif_tb_top.sv
// Purpose: Self-checking bench for the request signaling block
// Assumes: Two cores, security present on core 0 only
// Notes:   Table rows cover the request decision on core 0
`timescale 1ns/1ps
`include "cpuif_cfg.svh"
module cpuif_tb_top;
  // ************************************************************
  // Stimulus and observation
  // ************************************************************
  localparam logic [5:0] k_ctl = 6'h20;
  localparam logic [5:0] k_awr = 6'h10;
  localparam logic [5:0] k_ard = 6'h08;
  localparam logic [5:0] k_grp = 6'h04;
  localparam logic [5:0] k_sgi = 6'h02;
  localparam logic [5:0] k_spi = 6'h01;
  logic        clk;
  logic        rst_n;
  logic        cwr, awr, ard, gwr, sgi, spi, cpu, sec;
  logic [1:0]  lirq, lfiq, tgt, en, irq, fast_interrupt_request, wake, rsec, avld;
  wire  [1:0]  ack;
  logic [31:0] dat, ardat;
  logic [4:0]  gid, id0, id1;
  logic        p = 1'h0;
  int          miscompares = 0;
  int          tests_run = 0;
  int          nv0 = 0;
  int          nv1 = 0;
  int          s0, s1;
  // Row: pending, control word, legacy level, normal, fast
  logic [10:0] rows [18] = '{11'h007, 11'h085, 11'h0a7, 11'h0e5, 11'h02e, 11'h3ec,
    11'h107, 11'h306, 11'h126, 11'h314, 11'h115, 11'h00d, 11'h384, 11'h40a, 11'h41a,
    11'h439, 11'h729, 11'h410};

  cpuif_top i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .LEG_IRQ_I(lirq), .LEG_FIQ_I(lfiq),
    .CTRL_WR_I(cwr), .CTRL_CPU_I(cpu), .CTRL_SECURE_I(sec), .CTRL_WDATA_I(dat[6:0]),
    .APR_WR_I(awr), .APR_RD_I(ard), .APR_CPU_I(cpu), .APR_SECURE_I(sec),
    .APR_WDATA_I(dat), .GRP_WR_I(gwr), .GRP_SECURE_I(sec), .GRP_ID_I(gid),
    .GRP_VAL_I(tgt[0]), .SGI_SET_I(sgi), .SGI_ID_I(gid[3:0]), .SGI_TGT_I(tgt),
    .SPI_SET_I(spi), .SPI_ID_I(gid[3:0]), .ACK_I(ack), .IRQ_O(irq), .FIQ_O(fast_interrupt_request),
    .WAKE_O(wake), .REQ_SECURE_O(rsec), .ACK_VALID_O(avld), .ACK_ID0_O(id0),
    .ACK_ID1_O(id1), .APR_RDATA_O(ardat)
  );
  cpuif_core_model #(.DELAY(0)) i_core0 (.clk_i(clk), .rst_n_i(rst_n), .en_i(en[0]),
    .irq_i(irq[0]), .fiq_i(fast_interrupt_request[0]), .ack_o(ack[0]));
  cpuif_core_model #(.DELAY(3)) i_core1 (.clk_i(clk), .rst_n_i(rst_n), .en_i(en[1]),
    .irq_i(irq[1]), .fiq_i(fast_interrupt_request[1]), .ack_o(ack[1]));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    nv0 <= nv0 + int'(avld[0]);
    nv1 <= nv1 + int'(avld[1]);
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic op(input logic [5:0] k, input logic c, input logic s,
                    input logic [31:0] d, input logic [4:0] id, input logic [1:0] t);
    @(posedge clk);
    {cwr, awr, ard, gwr, sgi, spi} <= k;
    cpu <= c;
    sec <= s;
    dat <= d;
    gid <= id;
    tgt <= t;
    @(posedge clk);
    {cwr, awr, ard, gwr, sgi, spi} <= 6'h00;
  endtask

  task automatic finish_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    rst_n = 1'h0;
    {cwr, awr, ard, gwr, sgi, spi, cpu, sec} = 8'h00;
    {lirq, lfiq, tgt, en} = 8'h00;
    dat = 32'h0000_0000;
    gid = 5'h00;
    cyc(2);
    check({irq, fast_interrupt_request, wake, rsec, avld}, 10'h000);
    @(posedge clk);
    rst_n <= 1'h1;
    op(k_ard, 1'h0, 1'h1, 32'h0, 5'h00, 2'h0);
    cyc(1);
    check(ardat, 32'h0000_0000);
    op(k_awr, 1'h0, 1'h1, 32'h1111_2222, 5'h00, 2'h0);
    op(k_awr, 1'h0, 1'h0, 32'h3333_4444, 5'h00, 2'h0);
    op(k_ard, 1'h0, 1'h1, 32'h0, 5'h00, 2'h0);
    cyc(1);
    check(ardat, 32'h1111_2222);
    op(k_ard, 1'h0, 1'h0, 32'h0, 5'h00, 2'h0);
    cyc(1);
    check(ardat, 32'h3333_4444);
    op(k_awr, 1'h1, 1'h1, 32'h5555_6666, 5'h00, 2'h0);
    op(k_ard, 1'h1, 1'h0, 32'h0, 5'h00, 2'h0);
    cyc(1);
    check(ardat, 32'h5555_6666);
    foreach (rows[i]) begin
      if (rows[i][10] && !p) begin
        op(k_spi, 1'h0, 1'h0, 32'h0, 5'h00, 2'h0);
        p = 1'h1;
      end
      @(posedge clk);
      lirq <= {2{rows[i][2]}};
      lfiq <= {2{rows[i][2]}};
      op(k_ctl, 1'h0, 1'h1, {25'h0, rows[i][9:3]}, 5'h00, 2'h0);
      cyc(4);
      check(irq[0], rows[i][1]);
      check(fast_interrupt_request[0], rows[i][0]);
      check(wake[0], 1'h1);
    end
    check(rsec, 2'h1);
    op(k_grp, 1'h0, 1'h1, 32'h0, 5'h10, 2'h1);
    cyc(3);
    check(irq[0], 1'h1);
    check(rsec[0], 1'h0);
    op(k_grp, 1'h0, 1'h0, 32'h0, 5'h10, 2'h0);
    op(k_ctl, 1'h0, 1'h1, 32'h1, 5'h00, 2'h0);
    cyc(3);
    check(irq[0], 1'h0);
    @(posedge clk);
    lirq <= 2'h3;
    lfiq <= 2'h3;
    op(k_ctl, 1'h0, 1'h1, 32'h0, 5'h00, 2'h0);
    op(k_ctl, 1'h0, 1'h0, 32'h7f, 5'h00, 2'h0);
    op(k_ctl, 1'h1, 1'h0, 32'h5, 5'h00, 2'h0);
    cyc(4);
    check(fast_interrupt_request[0], 1'h1);
    check(irq[0], 1'h1);
    check(fast_interrupt_request[1], 1'h0);
    @(posedge clk);
    lirq <= 2'h0;
    lfiq <= 2'h0;
    op(k_ctl, 1'h0, 1'h1, 32'h3, 5'h00, 2'h0);
    op(k_ctl, 1'h1, 1'h1, 32'h3, 5'h00, 2'h0);
    s0 = nv0 + nv1;
    en <= 2'h3;
    cyc(20);
    check(nv0 + nv1 - s0, 1);
    check(id0, 5'h10);
    s0 = nv0;
    s1 = nv1;
    op(k_sgi, 1'h0, 1'h0, 32'h0, 5'h03, 2'h3);
    cyc(20);
    check(nv0 - s0, 1);
    check(nv1 - s1, 1);
    check({id1, id0}, 10'h063);
    check(irq, 2'h0);
    @(posedge clk);
    rst_n <= 1'h0;
    en <= 2'h0;
    lirq <= 2'h1;
    cyc(2);
    check({irq, fast_interrupt_request, wake, rsec, avld}, 10'h000);
    @(posedge clk);
    rst_n <= 1'h1;
    cyc(4);
    check({irq[0], fast_interrupt_request[0], wake[0]}, 3'h5);
    op(k_ctl, 1'h0, 1'h1, 32'h1, 5'h00, 2'h0);
    op(k_spi, 1'h0, 1'h0, 32'h0, 5'h00, 2'h0);
    cyc(3);
    check(irq[0], 1'h1);
    check(rsec, 2'h1);
    finish_test();
  end
endmodule
